// [design/reclocker_config_status_ctrl.sv]
// control and status logic of a serial-video reclocking distribution block
// assumes strap and analogue status pins are asynchronous; wishbone on clk_i
//
// Behaviour
// - exactly one input enabled: strap 1-2 coax, 2-3 optical, or remote override
// - all eight coax outputs always driven, no enable control
// - optical transmitter on by strap 1-2 or remote, off by 2-3 or remote
// - mode strap: 1-2 auto, pin 2 only fixed 270, 2-3 bypass
// - auto mode locks at 143, 177, 270 or 360 Mb/s
// - bypass passes input unreclocked, any rate from 50 to 540 Mb/s
// - remote mode choices accepted; without one, strap mode rules
// - scope strap 1-2 ignores remote commands; 2-3 accepts both; locate and firmware update still act under 1-2
// - fault indicator steady on for an internal fault, dark with no fault and a good signal
// - fault indicator long-flashes on no input or rate mismatch
// - bus activity indicator long-flashes on a locate command
// - bus activity indicator short-flashes during bus traffic, dark when idle
// - config indicator short-flashes on init, mode change, firmware update
// - carrier present indicator lit while carrier detected on selected input
// - outputs muted on no input or overlong cable; other carriers pass
// - power indicator lit while powered and operating
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "reclocker_defines.svh"

module reclocker_config_status_ctrl #(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o,
	// straps, bit 0 = pins 1-2 fitted, bit 1 = pins 2-3 fitted
	input wire logic [1:0] input_select_strap_i,
	input wire logic [1:0] mode_strap_i,
	input wire logic [1:0] optical_tx_strap_i,
	input wire logic [1:0] control_scope_strap_i,
	// analogue status
	input wire logic carrier_detect_i,
	input wire logic cable_too_long_i,
	input wire logic [2:0] detected_rate_i,
	input wire logic internal_fault_i,
	input wire logic bus_traffic_i,
	input wire logic power_good_i,
	// signal path control
	output logic coax_input_en_o,
	output logic optical_input_en_o,
	output logic optical_tx_en_o,
	output reclocker_pkg::mode_e reclock_mode_o,
	output logic bypass_o,
	output logic outputs_mute_o,
	output logic [`COAX_OUTS-1:0] coax_out_en_o,
	// indicators
	output logic fault_indicator_o,
	output logic bus_activity_indicator_o,
	output logic config_indicator_o,
	output logic power_indicator_o,
	output logic carrier_present_indicator_o
);

	function automatic logic pos23(input logic [1:0] s);
		return s == 2'h2;
	endfunction

	function automatic logic [31:0] lane_merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] sel);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = n[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// three-flop input sync; a change counts once stages two and three agree
	logic [`NPINS-1:0] pins;
	logic [`NPINS-1:0] s1_q;
	logic [`NPINS-1:0] s2_q;
	logic [`NPINS-1:0] s3_q;
	logic [`NPINS-1:0] flt_q;
	assign pins = {control_scope_strap_i, optical_tx_strap_i, mode_strap_i,
		input_select_strap_i, detected_rate_i, power_good_i, bus_traffic_i,
		internal_fault_i, cable_too_long_i, carrier_detect_i};
	for (genvar i = 0; i < `NPINS; i++) begin : g_sync
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				s1_q[i] <= 1'b0;
				s2_q[i] <= 1'b0;
				s3_q[i] <= 1'b0;
				flt_q[i] <= 1'b0;
			end else begin
				s1_q[i] <= pins[i];
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
				if (s2_q[i] == s3_q[i]) begin
					flt_q[i] <= s3_q[i];
				end
			end
		end
	end

	wire logic carrier = flt_q[0];
	wire logic cable_long = flt_q[1];
	wire logic int_fault = flt_q[2];
	wire logic traffic = flt_q[3];
	wire logic pwr_good = flt_q[4];
	// the rate code is filtered per bit; a settling code may show one odd value
	wire reclocker_pkg::rate_e rate = reclocker_pkg::rate_e'(flt_q[7:5]);
	wire logic [7:0] strap_raw = flt_q[15:8];

	// millisecond tick, shared by every timer and both flash patterns
	logic [`TICK_W-1:0] tick_cnt_q;
	logic tick_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (tick_cnt_q == `TICK_W'(TICK_CYCLES - 1)) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + `TICK_W'(1);
			tick_q <= 1'b0;
		end
	end

	// strap debounce: value must hold for the whole window before it is used
	logic [7:0] strap_prev_q;
	logic [7:0] strap_q;
	logic [`MS_W-1:0] deb_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strap_prev_q <= `STRAP_RST;
			strap_q <= `STRAP_RST;
			deb_q <= '0;
		end else if (strap_raw != strap_prev_q) begin
			strap_prev_q <= strap_raw;
			deb_q <= '0;
		end else if (deb_q == `MS_W'(`DEBOUNCE_MS)) begin
			strap_q <= strap_prev_q;
		end else if (tick_q) begin
			deb_q <= deb_q + `MS_W'(1);
		end
	end

	// effective configuration
	reclocker_pkg::ctrl_s ctrl_q;
	reclocker_pkg::cfg_s cfg_d;
	reclocker_pkg::cfg_s cfg_q;
	reclocker_pkg::mode_e strap_mode;
	wire logic remote_ok = pos23(strap_q[7:6]);

	always_comb begin
		case (strap_q[3:2])
			2'h1: strap_mode = reclocker_pkg::M_AUTO;
			2'h0: strap_mode = reclocker_pkg::M_270;
			2'h2: strap_mode = reclocker_pkg::M_BYPASS;
			default: strap_mode = reclocker_pkg::M_AUTO;
		endcase
	end

	always_comb begin
		// an unfitted input strap falls back to coax so one input stays live
		cfg_d.input_optical = pos23(strap_q[1:0]);
		cfg_d.tx_en = !pos23(strap_q[5:4]);
		cfg_d.mode = strap_mode;
		if (remote_ok && ctrl_q.rin_en) begin
			cfg_d.input_optical = ctrl_q.remote_input_choice;
		end
		if (remote_ok && ctrl_q.rtx_en) begin
			cfg_d.tx_en = ctrl_q.remote_optical_tx_choice;
		end
		if (remote_ok && ctrl_q.rmode_en) begin
			cfg_d.mode = ctrl_q.rmode;
		end
	end

	wire logic cfg_chg = cfg_d != cfg_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_q <= '{input_optical: 1'b0, tx_en: 1'b1, mode: reclocker_pkg::M_AUTO};
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// initialisation and mode-change state
	reclocker_pkg::state_e st_q;
	logic [`MS_W-1:0] st_ms_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= reclocker_pkg::ST_INIT;
			st_ms_q <= '0;
		end else begin
			case (st_q)
				reclocker_pkg::ST_INIT: begin
					if (st_ms_q == `MS_W'(`INIT_MS)) begin
						st_q <= reclocker_pkg::ST_RUN;
						st_ms_q <= '0;
					end else if (tick_q) begin
						st_ms_q <= st_ms_q + `MS_W'(1);
					end
				end
				reclocker_pkg::ST_RUN: begin
					if (cfg_chg) begin
						st_q <= reclocker_pkg::ST_CHANGE;
						st_ms_q <= '0;
					end
				end
				reclocker_pkg::ST_CHANGE: begin
					if (cfg_chg) begin
						st_ms_q <= '0;
					end else if (st_ms_q == `MS_W'(`CHANGE_MS)) begin
						st_q <= reclocker_pkg::ST_RUN;
						st_ms_q <= '0;
					end else if (tick_q) begin
						st_ms_q <= st_ms_q + `MS_W'(1);
					end
				end
				default: begin
					st_q <= reclocker_pkg::ST_INIT;
					st_ms_q <= '0;
				end
			endcase
		end
	end

	// flash patterns
	logic [`MS_W-1:0] lf_q;
	logic [`MS_W-1:0] sf_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lf_q <= '0;
			sf_q <= '0;
		end else if (tick_q) begin
			lf_q <= (lf_q == `MS_W'(`LONG_PERIOD_MS - 1)) ? '0 : lf_q + `MS_W'(1);
			sf_q <= (sf_q == `MS_W'(`SHORT_PERIOD_MS - 1)) ? '0 : sf_q + `MS_W'(1);
		end
	end

	wire logic long_on = lf_q < `MS_W'(`LONG_ON_MS);
	wire logic short_on = sf_q < `MS_W'(`SHORT_ON_MS);

	// signal quality against the selected mode
	logic rate_ok;
	always_comb begin
		case (cfg_q.mode)
			reclocker_pkg::M_AUTO,
			reclocker_pkg::M_AUTO_RECLOCK: rate_ok = rate inside {reclocker_pkg::R_143,
				reclocker_pkg::R_177, reclocker_pkg::R_270, reclocker_pkg::R_360};
			reclocker_pkg::M_BYPASS: rate_ok = 1'b1;
			reclocker_pkg::M_143: rate_ok = rate == reclocker_pkg::R_143;
			reclocker_pkg::M_177: rate_ok = rate == reclocker_pkg::R_177;
			reclocker_pkg::M_270: rate_ok = rate == reclocker_pkg::R_270;
			reclocker_pkg::M_360: rate_ok = rate == reclocker_pkg::R_360;
			reclocker_pkg::M_540: rate_ok = rate == reclocker_pkg::R_540;
			default: rate_ok = 1'b0;
		endcase
	end

	wire logic mismatch = !carrier || !rate_ok;

	// outputs, all registered
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			coax_input_en_o <= 1'b1;
			optical_input_en_o <= 1'b0;
			optical_tx_en_o <= 1'b0;
			reclock_mode_o <= reclocker_pkg::M_AUTO;
			bypass_o <= 1'b0;
			outputs_mute_o <= 1'b1;
			coax_out_en_o <= '1;
			fault_indicator_o <= 1'b0;
			bus_activity_indicator_o <= 1'b0;
			config_indicator_o <= 1'b0;
			power_indicator_o <= 1'b0;
			carrier_present_indicator_o <= 1'b0;
		end else begin
			coax_input_en_o <= !cfg_q.input_optical;
			optical_input_en_o <= cfg_q.input_optical;
			optical_tx_en_o <= cfg_q.tx_en;
			reclock_mode_o <= cfg_q.mode;
			bypass_o <= cfg_q.mode == reclocker_pkg::M_BYPASS;
			outputs_mute_o <= !carrier || cable_long;
			coax_out_en_o <= '1;
			if (int_fault) begin
				fault_indicator_o <= 1'b1;
			end else begin
				fault_indicator_o <= mismatch && long_on;
			end
			if (ctrl_q.locate) begin
				bus_activity_indicator_o <= long_on;
			end else begin
				bus_activity_indicator_o <= traffic && short_on;
			end
			config_indicator_o <= short_on && (st_q != reclocker_pkg::ST_RUN ||
				ctrl_q.fw_update);
			power_indicator_o <= pwr_good;
			carrier_present_indicator_o <= carrier;
		end
	end

	// interrupt events
	logic carrier_prev_q;
	logic mismatch_prev_q;
	logic [`IRQ_W-1:0] ev;
	logic [`IRQ_W-1:0] irq_stat_q;
	logic [`IRQ_W-1:0] irq_mask_q;
	logic [`IRQ_W-1:0] irq_clr;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			carrier_prev_q <= 1'b0;
			mismatch_prev_q <= 1'b0;
		end else begin
			carrier_prev_q <= carrier;
			mismatch_prev_q <= mismatch;
		end
	end

	always_comb begin
		ev = '0;
		ev[`IRQ_CARRIER] = carrier != carrier_prev_q;
		ev[`IRQ_CONFIG] = cfg_chg;
		ev[`IRQ_SIGNAL] = mismatch && !mismatch_prev_q;
	end

	// wishbone slave, one wait state, unmapped reads give zero
	wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	logic [31:0] wr_word;
	logic [31:0] rd_d;
	assign irq_clr = (req && wb_we_i && wb_adr_i == `ADR_IRQ_STAT && wb_sel_i[0]) ?
		wb_dat_i[`IRQ_W-1:0] : '0;
	assign wr_word = lane_merge({22'h0, ctrl_q}, wb_dat_i, wb_sel_i);

	always_comb begin
		case (wb_adr_i)
			`ADR_CTRL: rd_d = {22'h0, ctrl_q};
			`ADR_STATUS: rd_d = {10'h0, st_q, mismatch, cable_long, carrier, rate,
				remote_ok, cfg_q, strap_q};
			`ADR_IRQ_STAT: rd_d = {29'h0, irq_stat_q};
			`ADR_IRQ_MASK: rd_d = {29'h0, irq_mask_q};
			default: rd_d = 32'h0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? rd_d : 32'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= `CTRL_RST;
			irq_mask_q <= `IRQ_RST;
		end else if (req && wb_we_i) begin
			if (wb_adr_i == `ADR_CTRL) begin
				ctrl_q <= reclocker_pkg::ctrl_s'(wr_word[`CTRL_W-1:0]);
			end
			if (wb_adr_i == `ADR_IRQ_MASK && wb_sel_i[0]) begin
				irq_mask_q <= wb_dat_i[`IRQ_W-1:0];
			end
		end
	end

	// a new event wins over a write-one clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_q <= `IRQ_RST;
			irq_o <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | ev;
			irq_o <= |(((irq_stat_q & ~irq_clr) | ev) & irq_mask_q);
		end
	end

endmodule

// [design/reclocker_defines.svh]
// constants for the reclocker control and status block
// assumes a 40 MHz system clock and a classic wishbone register bus
`ifndef RECLOCKER_DEFINES_SVH
`define RECLOCKER_DEFINES_SVH

`define CLK_HZ 40000000
`define TICK_US 1000
`define TICK_CYCLES ((`CLK_HZ / 1000000) * `TICK_US)
`define TICK_W 16

`define DEBOUNCE_MS 20
`define INIT_MS 500
`define CHANGE_MS 250
`define LONG_PERIOD_MS 1000
`define LONG_ON_MS 600
`define SHORT_PERIOD_MS 200
`define SHORT_ON_MS 100
`define MS_W 10

`define ADR_CTRL 8'h00
`define ADR_STATUS 8'h04
`define ADR_IRQ_STAT 8'h08
`define ADR_IRQ_MASK 8'h0c

`define CTRL_W 10
`define CTRL_RST 10'h000
`define IRQ_W 3
`define IRQ_CARRIER 0
`define IRQ_CONFIG 1
`define IRQ_SIGNAL 2
`define IRQ_RST 3'h0

`define STRAP_RST 8'h55
`define COAX_OUTS 8
`define NPINS 16

`endif

// [design/reclocker_pkg.sv]
// types for the reclocker control and status block
// assumes reclocker_defines.svh for the numeric constants
package reclocker_pkg;

	typedef enum logic [2:0] {
		M_AUTO = 3'h0,
		M_AUTO_RECLOCK = 3'h1,
		M_BYPASS = 3'h2,
		M_143 = 3'h3,
		M_177 = 3'h4,
		M_270 = 3'h5,
		M_360 = 3'h6,
		M_540 = 3'h7
	} mode_e;

	typedef enum logic [2:0] {
		R_NONE = 3'h0,
		R_143 = 3'h1,
		R_177 = 3'h2,
		R_270 = 3'h3,
		R_360 = 3'h4,
		R_540 = 3'h5
	} rate_e;

	typedef enum logic [1:0] {
		ST_INIT = 2'h0,
		ST_RUN = 2'h1,
		ST_CHANGE = 2'h3
	} state_e;

	typedef struct packed {
		logic input_optical;
		logic tx_en;
		mode_e mode;
	} cfg_s;

	typedef struct packed {
		logic fw_update;
		logic locate;
		mode_e rmode;
		logic rmode_en;
		logic remote_optical_tx_choice;
		logic rtx_en;
		logic remote_input_choice;
		logic rin_en;
	} ctrl_s;

endpackage

// [dv/net_ctrl_model.sv]
// frame network controller model: remote commands over wishbone
// assumes a classic single-cycle slave; ack wait bounded here
`timescale 1ns/1ps
module net_ctrl_model (
	// clock
	input wire logic clk_i,
	// wishbone master
	output logic wb_cyc_o,
	output logic wb_stb_o,
	output logic wb_we_o,
	output logic [7:0] wb_adr_o,
	output logic [3:0] wb_sel_o,
	output logic [31:0] wb_dat_o,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_i,
	// frame bus activity
	output logic bus_traffic_o
);
	initial begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o = 1'b0;
		wb_adr_o = 8'h00;
		wb_sel_o = 4'h0;
		wb_dat_o = 32'h0;
		bus_traffic_o = 1'b0;
	end
	task automatic set_traffic(input logic v);
		@(posedge clk_i);
		bus_traffic_o <= v;
	endtask
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output bit ok);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o <= we;
		wb_adr_o <= a;
		wb_sel_o <= 4'hf;
		wb_dat_o <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_i !== 1'b1 && n < 50);
		r = wb_dat_i;
		ok = n < 50;
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		// released address and data lines go to the inverse, never a stale value
		wb_adr_o <= ~a;
		wb_dat_o <= ~d;
		@(posedge clk_i);
	endtask
endmodule

// [dv/reclocker_asserts.sv]
// port assertions for the reclocker control block
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module reclocker_asserts (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// status inputs
	input wire logic carrier_detect_i,
	input wire logic cable_too_long_i,
	input wire logic internal_fault_i,
	input wire logic power_good_i,
	// outputs watched
	input wire logic coax_input_en_o,
	input wire logic optical_input_en_o,
	input wire reclocker_pkg::mode_e reclock_mode_o,
	input wire logic bypass_o,
	input wire logic outputs_mute_o,
	input wire logic [7:0] coax_out_en_o,
	input wire logic fault_indicator_o,
	input wire logic power_indicator_o,
	input wire logic carrier_present_indicator_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// eight cycles cover the sync chain plus the output register
	sequence s_live;
		(carrier_detect_i && !cable_too_long_i) [*8];
	endsequence
	sequence s_dead;
		!carrier_detect_i [*8];
	endsequence
	property p_coax_out;
		coax_out_en_o == 8'hff;
	endproperty
	property p_one_input;
		coax_input_en_o != optical_input_en_o;
	endproperty
	property p_bypass;
		bypass_o == (reclock_mode_o == reclocker_pkg::M_BYPASS);
	endproperty
	property p_mute;
		s_dead |-> outputs_mute_o;
	endproperty
	property p_pass;
		s_live |-> !outputs_mute_o;
	endproperty
	property p_carrier;
		s_live |-> carrier_present_indicator_o;
	endproperty
	property p_fault;
		internal_fault_i [*8] |-> fault_indicator_o;
	endproperty
	property p_power;
		power_good_i [*8] |-> power_indicator_o;
	endproperty
	a_coax_out: assert property (p_coax_out) else $error("coax outputs gated");
	a_one_input: assert property (p_one_input) else $error("input enables");
	a_bypass: assert property (p_bypass) else $error("bypass vs mode");
	a_mute: assert property (p_mute) else $error("not muted");
	a_pass: assert property (p_pass) else $error("muted on carrier");
	a_carrier: assert property (p_carrier) else $error("carrier dark");
	a_fault: assert property (p_fault) else $error("fault not steady");
	a_power: assert property (p_power) else $error("power dark");
endmodule

bind reclocker_config_status_ctrl reclocker_asserts i_asserts (.clk_i, .rst_i,
	.carrier_detect_i, .cable_too_long_i, .internal_fault_i, .power_good_i,
	.coax_input_en_o, .optical_input_en_o, .reclock_mode_o, .bypass_o, .outputs_mute_o,
	.coax_out_en_o, .fault_indicator_o, .power_indicator_o, .carrier_present_indicator_o);

// [dv/testbench.sv]
// self-checking bench for the reclocker control block
// assumes the controller model as bus master; tick shortened to 4 cycles
`timescale 1ns/1ps
`include "reclocker_defines.svh"
module testbench;
	localparam int TICK = 4;
	localparam int SETTLE = (`DEBOUNCE_MS + 10) * TICK;
	localparam int LONG = `LONG_PERIOD_MS * TICK;
	logic clk_i = 1'b0, rst_i = 1'b1;
	logic [1:0] input_select_strap_i = 2'b01, mode_strap_i = 2'b01;
	logic [1:0] optical_tx_strap_i = 2'b01, control_scope_strap_i = 2'b01;
	logic carrier_detect_i = 1'b1, cable_too_long_i = 1'b0, internal_fault_i = 1'b0;
	logic power_good_i = 1'b1, bus_traffic_i;
	logic [2:0] detected_rate_i = 3'h3;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
	logic [7:0] wb_adr_i, coax_out_en_o;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic coax_input_en_o, optical_input_en_o, optical_tx_en_o, bypass_o, outputs_mute_o;
	logic fault_indicator_o, bus_activity_indicator_o, config_indicator_o;
	logic power_indicator_o, carrier_present_indicator_o;
	reclocker_pkg::mode_e reclock_mode_o;
	logic [1:0] st_mode [3] = '{2'b00, 2'b10, 2'b01};
	logic [2:0] st_exp [3] = '{3'h5, 3'h2, 3'h0};
	int fail_count = 0, compares = 0;
	always #12.5 clk_i = ~clk_i;
	reclocker_config_status_ctrl #(.TICK_CYCLES(TICK)) i_dut (.clk_i, .rst_i, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o,
		.input_select_strap_i, .mode_strap_i, .optical_tx_strap_i, .control_scope_strap_i,
		.carrier_detect_i, .cable_too_long_i, .detected_rate_i, .internal_fault_i,
		.bus_traffic_i, .power_good_i, .coax_input_en_o, .optical_input_en_o,
		.optical_tx_en_o, .reclock_mode_o, .bypass_o, .outputs_mute_o, .coax_out_en_o,
		.fault_indicator_o, .bus_activity_indicator_o, .config_indicator_o,
		.power_indicator_o, .carrier_present_indicator_o);
	net_ctrl_model i_ctl (.clk_i, .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i),
		.wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i), .wb_dat_i(wb_dat_o),
		.wb_ack_i(wb_ack_o), .bus_traffic_o(bus_traffic_i));
	task automatic give_verdict();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got, int tol = 0);
		compares++;
		if ($isunknown(got) ||
			(tol == 0 ? got !== exp : (got > exp + tol || got + tol < exp))) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(logic we, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
		bit ok;
		i_ctl.xfer(we, a, d, r, ok);
		if (!ok) begin
			fail_count++;
			give_verdict();
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(string what, logic [7:0] a, logic [31:0] exp, logic [31:0] msk = '1);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(what, exp, r & msk);
	endtask
	// polls the state field; init and change both end in run
	task automatic wait_run();
		logic [31:0] r;
		for (int n = 0; n < 4000; n++) begin
			bus(1'b0, `ADR_STATUS, 32'h0, r);
			if (r[21:20] === 2'h1)
				return;
		end
		fail_count++;
		give_verdict();
	endtask
	task automatic flash(output int f, output int b, output int c);
		f = 0;
		b = 0;
		c = 0;
		repeat (LONG) begin
			@(posedge clk_i);
			f += fault_indicator_o;
			b += bus_activity_indicator_o;
			c += config_indicator_o;
		end
	endtask
	initial begin
		int f, b, c;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		wait_run();
		chk("config dark", 0, config_indicator_o);
		chk("coax in", 1, coax_input_en_o);
		chk("tx on", 1, optical_tx_en_o);
		chk("auto", 0, reclock_mode_o);
		chk("fault dark", 0, fault_indicator_o);
		chk("bus idle", 0, bus_activity_indicator_o);
		chk("power on", 1, power_indicator_o);
		chk("carrier lit", 1, carrier_present_indicator_o);
		chk("coax outs", 8'hff, coax_out_en_o);
		chk("not muted", 0, outputs_mute_o);
		rd("ctrl", `ADR_CTRL, 32'h0);
		rd("mask", `ADR_IRQ_MASK, 32'h0);
		rd("unmapped", 8'h10, 32'h0);
		wr(`ADR_CTRL, 32'h3);
		repeat (4) @(posedge clk_i);
		chk("locked out", 1, coax_input_en_o);
		control_scope_strap_i <= 2'b10;
		repeat (SETTLE) @(posedge clk_i);
		chk("remote optical", 1, optical_input_en_o);
		for (int m = 0; m < 8; m++) begin
			wr(`ADR_CTRL, (32'(m) << 5) | 32'h14);
			repeat (4) @(posedge clk_i);
			chk("remote mode", m, reclock_mode_o);
			chk("remote tx", 0, optical_tx_en_o);
		end
		wr(`ADR_CTRL, 32'h0);
		wr(`ADR_IRQ_MASK, 32'h2);
		for (int i = 0; i < 3; i++) begin
			mode_strap_i <= st_mode[i];
			input_select_strap_i <= i == 1 ? 2'b01 : 2'b10;
			optical_tx_strap_i <= i == 1 ? 2'b01 : 2'b10;
			repeat (SETTLE) @(posedge clk_i);
			chk("strap mode", st_exp[i], reclock_mode_o);
			chk("strap input", i != 1, optical_input_en_o);
			chk("strap tx", i == 1, optical_tx_en_o);
			chk("strap bypass", i == 1, bypass_o);
			chk("change irq", 1, irq_o);
			rd("change state", `ADR_STATUS, 32'h3 << 20, 32'h3 << 20);
			wr(`ADR_IRQ_STAT, 32'h7);
			repeat (3) @(posedge clk_i);
			chk("irq cleared", 0, irq_o);
		end
		wait_run();
		wr(`ADR_IRQ_MASK, 32'h1);
		chk("irq quiet", 0, irq_o);
		i_ctl.set_traffic(1'b1);
		carrier_detect_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		chk("carrier irq", 1, irq_o);
		chk("carrier dark", 0, carrier_present_indicator_o);
		chk("no input mute", 1, outputs_mute_o);
		rd("irq stat", `ADR_IRQ_STAT, 32'h5);
		flash(f, b, c);
		chk("no input flash", `LONG_ON_MS * TICK, f, 8);
		chk("traffic flash", `SHORT_ON_MS * TICK * 5, b, 8);
		chk("run config dark", 0, c);
		i_ctl.set_traffic(1'b0);
		carrier_detect_i <= 1'b1;
		detected_rate_i <= 3'h5;
		wr(`ADR_CTRL, 32'h300);
		flash(f, b, c);
		chk("rate flash", `LONG_ON_MS * TICK, f, 8);
		chk("locate flash", `LONG_ON_MS * TICK, b, 8);
		chk("update flash", `SHORT_ON_MS * TICK * 5, c, 8);
		cable_too_long_i <= 1'b1;
		internal_fault_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		chk("long cable mute", 1, outputs_mute_o);
		chk("fault steady", 1, fault_indicator_o);
		give_verdict();
	end
endmodule
